// ---- rtl/sxa_alu.sv ----
// Datapath slice: literal/file minus accumulator, exclusive-or, nibble exchange.
// Holds the accumulator, the borrow, nibble borrow and zero flags, and a
// registered write port back into the register file.
// Assumes the decoder presents one operation per clock with the file value
// already read for file_addr; the register file takes file_we/file_wdata.
// Assumes the register file completes a write before the next read of it.
//
// Function
// - Literal-minus-acc puts literal minus accumulator into the accumulator.
// - Literal-minus-acc sets borrow when acc <= literal and nibble borrow when low nibbles compare so.
// - File-minus-acc sends file value minus accumulator to the selected destination.
// - File-minus-acc sets borrow when acc <= file and nibble borrow when low nibbles compare so.
// - Destination select 0 writes the accumulator, 1 writes the addressed file register.
// - Exclusive-or-file xors acc with file to the destination, touching only zero.
// - Nibble exchange swaps file nibbles to the destination and touches no flag.
// - Exclusive-or-literal xors acc with the literal into the accumulator, touching only zero.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "sxa_defines.svh"
module sxa_alu
   import sxa_pkg::*;
#(
   parameter int DATA_W = `SXA_DATA_W,
   parameter int ADDR_W = `SXA_ADDR_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire sxa_op_t op,
   input wire logic [DATA_W-1:0] literal,
   input wire logic [ADDR_W-1:0] file_addr,
   input wire logic [DATA_W-1:0] file_rdata,
   input wire logic dest_sel,
   output logic [DATA_W-1:0] acc,
   output logic borrow_flag,
   output logic nibble_borrow_flag,
   output logic zero_flag,
   output logic file_we,
   output logic [ADDR_W-1:0] file_waddr,
   output logic [DATA_W-1:0] file_wdata
);

   // Elaboration checks: nibble logic needs exactly one byte
   if (DATA_W != 8) begin : g_bad_width
      $error("sxa_alu supports only DATA_W of 8");
   end
   // A file address needs at least one bit
   if (ADDR_W < 1) begin : g_bad_addr
      $error("sxa_alu needs ADDR_W of at least 1");
   end
   // Nibble boundaries must meet in the middle of the byte
   if (`SXA_HI_LSB != `SXA_LO_MSB + 1) begin : g_bad_nibble
      $error("sxa_alu nibble boundaries do not meet");
   end

   // Accumulator state
   logic [DATA_W-1:0] acc_ff;
   logic [DATA_W-1:0] nxt_acc;
   // Borrow flag state, 1 means no borrow
   logic borrow_ff;
   logic nxt_borrow;
   // Nibble borrow flag state, 1 means no borrow out of the low nibble
   logic nib_ff;
   logic nxt_nib;
   // Zero flag state
   logic zero_ff;
   logic nxt_zero;
   // File write port state
   logic we_ff;
   logic nxt_we;
   logic [ADDR_W-1:0] waddr_ff;
   logic [ADDR_W-1:0] nxt_waddr;
   logic [DATA_W-1:0] wdata_ff;
   logic [DATA_W-1:0] nxt_wdata;
   // Decoded controls of the operation presented this cycle
   logic op_valid;
   logic is_sub;
   logic upd_zero;
   logic use_literal;
   logic to_file;
   logic wr_acc;
   logic wr_file;
   // Operand and candidate results
   logic [DATA_W-1:0] src;
   logic [DATA_W-1:0] diff;
   logic [DATA_W-1:0] xor_res;
   logic [DATA_W-1:0] swap_res;
   logic [DATA_W-1:0] result;
   logic acc_le_src;
   logic nib_le_src;

   // Decode: operand source, flags touched and destination
   // Codes 6 and 7 and no-operation change nothing at all
   always_comb begin
      op_valid = 1'b0;
      is_sub = 1'b0;
      upd_zero = 1'b0;
      use_literal = 1'b0;
      to_file = `SXA_DEST_ACC;
      unique case (op)
         SXA_OP_NONE: begin
            op_valid = 1'b0;
         end
         SXA_OP_LITERAL_MINUS_ACC: begin
            op_valid = 1'b1;
            is_sub = 1'b1;
            upd_zero = 1'b1;
            use_literal = 1'b1;
         end
         SXA_OP_FILE_MINUS_ACC: begin
            op_valid = 1'b1;
            is_sub = 1'b1;
            upd_zero = 1'b1;
            to_file = dest_sel;
         end
         SXA_OP_EXCLUSIVE_OR_FILE: begin
            op_valid = 1'b1;
            upd_zero = 1'b1;
            to_file = dest_sel;
         end
         SXA_OP_EXCLUSIVE_OR_LITERAL: begin
            op_valid = 1'b1;
            upd_zero = 1'b1;
            use_literal = 1'b1;
         end
         SXA_OP_NIBBLE_EXCHANGE: begin
            op_valid = 1'b1;
            to_file = dest_sel;
         end
         default: begin
            op_valid = 1'b0;
         end
      endcase
   end

   // Literal ops never write the file, whatever dest_sel says
   // destination decode
   assign wr_acc = op_valid && (to_file == `SXA_DEST_ACC);
   assign wr_file = op_valid && (to_file == `SXA_DEST_FILE);

   assign src = use_literal ? literal : file_rdata;

   assign diff = DATA_W'(src - acc_ff); // Two's complement, wraps within the byte

   assign xor_res = acc_ff ^ src;

   for (genvar i = 0; i < DATA_W; i++) begin : g_swap
      if (i <= `SXA_LO_MSB) begin : g_lo
         // Low result bits take the high file nibble
         assign swap_res[i] = file_rdata[i+`SXA_HI_LSB];
      end else begin : g_hi
         // High result bits take the low file nibble
         assign swap_res[i] = file_rdata[i-`SXA_HI_LSB];
      end
   end

   // Unsigned compares: the flags read 1 exactly when no borrow occurs
   // compare against the operand, literal or file value
   assign acc_le_src = (acc_ff <= src);
   assign nib_le_src = (acc_ff[`SXA_LO_MSB:0] <= src[`SXA_LO_MSB:0]);

   // Result select by operation
   always_comb begin
      result = '0;
      unique case (op)
         SXA_OP_NONE: begin
            result = '0;
         end
         SXA_OP_LITERAL_MINUS_ACC, SXA_OP_FILE_MINUS_ACC: begin
            result = diff;
         end
         SXA_OP_EXCLUSIVE_OR_FILE, SXA_OP_EXCLUSIVE_OR_LITERAL: begin
            result = xor_res;
         end
         SXA_OP_NIBBLE_EXCHANGE: begin
            result = swap_res;
         end
         default: begin
            result = '0;
         end
      endcase
   end

   always_comb begin
      nxt_acc = acc_ff;
      if (wr_acc) begin
         nxt_acc = result;
      end
   end

   // Accumulator register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_ff <= `SXA_ACC_RST;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   always_comb begin
      nxt_borrow = borrow_ff;
      if (op_valid && is_sub) begin
         nxt_borrow = acc_le_src;
      end
   end

   // Borrow register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         borrow_ff <= `SXA_FLAG_RST;
      end else begin
         borrow_ff <= nxt_borrow;
      end
   end

   always_comb begin
      nxt_nib = nib_ff;
      if (op_valid && is_sub) begin
         nxt_nib = nib_le_src;
      end
   end

   // Nibble borrow register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nib_ff <= `SXA_FLAG_RST;
      end else begin
         nib_ff <= nxt_nib;
      end
   end

   // Exclusive-or ops update only this flag; the exchange updates none
   // zero from result
   always_comb begin
      nxt_zero = zero_ff;
      if (op_valid && upd_zero) begin
         nxt_zero = (result == '0);
      end
   end

   // Zero register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zero_ff <= `SXA_FLAG_RST;
      end else begin
         zero_ff <= nxt_zero;
      end
   end

   // Write strobe lasts one cycle; the file holds the value after the edge
   // file write strobe
   always_comb begin
      nxt_we = 1'b0;
      if (wr_file) begin
         nxt_we = 1'b1;
      end
   end

   // Write strobe register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         we_ff <= `SXA_WE_RST;
      end else begin
         we_ff <= nxt_we;
      end
   end

   always_comb begin
      nxt_waddr = waddr_ff;
      nxt_wdata = wdata_ff;
      if (wr_file) begin
         nxt_waddr = file_addr;
         nxt_wdata = result;
      end
   end

   // Write address and data registers, held until the next write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waddr_ff <= '0;
         wdata_ff <= `SXA_WDATA_RST;
      end else begin
         waddr_ff <= nxt_waddr;
         wdata_ff <= nxt_wdata;
      end
   end

   // Accumulator output
   assign acc = acc_ff;
   // Status flag outputs
   assign borrow_flag = borrow_ff;
   assign nibble_borrow_flag = nib_ff;
   assign zero_flag = zero_ff;
   // File write port outputs
   assign file_we = we_ff;
   assign file_waddr = waddr_ff;
   assign file_wdata = wdata_ff;

endmodule // sxa_alu

// ---- pkg/sxa_defines.svh ----
// Constants for the subtract / exclusive-or / nibble exchange datapath.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef SXA_DEFINES_SVH
`define SXA_DEFINES_SVH
`define SXA_DATA_W 8
`define SXA_ADDR_W 7
`define SXA_ACC_RST 8'h00
`define SXA_FLAG_RST 1'b0
`define SXA_WE_RST 1'b0
`define SXA_WDATA_RST 8'h00
`define SXA_DEST_ACC 1'b0
`define SXA_DEST_FILE 1'b1
`define SXA_LO_MSB 3
`define SXA_HI_LSB 4
`endif

// ---- pkg/sxa_pkg.sv ----
// Types for the subtract / exclusive-or / nibble exchange datapath.
// Assumes the defines header is on the include path.
`include "sxa_defines.svh"
package sxa_pkg;
   // Operation codes driven by the instruction decoder
   typedef enum logic [2:0] {
      SXA_OP_NONE = 3'h0,
      SXA_OP_LITERAL_MINUS_ACC = 3'h1,
      SXA_OP_FILE_MINUS_ACC = 3'h2,
      SXA_OP_EXCLUSIVE_OR_FILE = 3'h3,
      SXA_OP_EXCLUSIVE_OR_LITERAL = 3'h4,
      SXA_OP_NIBBLE_EXCHANGE = 3'h5
   } sxa_op_t;
endpackage

// ---- verif/sxa_rf_model.sv ----
// Register file model on the datapath's file port.
// Assumes a combinational read and one write per clock.
`timescale 1ns/100ps
module sxa_rf_model (
   input wire logic clk,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata
);
   logic [7:0] mem [128];
   // Read of the addressed byte
   assign rd_data = mem[rd_addr];
   // Write back on the strobe
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule // sxa_rf_model

// ---- verif/sxa_alu_props.sv ----
// Checker on the datapath ports.
// Assumes the bind below onto sxa_alu.
`timescale 1ns/100ps
module sxa_alu_props
   import sxa_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic dest_sel,
   input wire logic file_we,
   input wire logic borrow_flag,
   input wire logic nibble_borrow_flag,
   input wire logic zero_flag,
   input wire sxa_op_t op,
   input wire logic [7:0] literal,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] acc,
   input wire logic [7:0] file_wdata
);
   logic [7:0] a_ff, k_ff, f_ff;
   // Operands as seen at the taking edge
   always_ff @(posedge clk) {a_ff, k_ff, f_ff} <= {acc, literal, file_rdata};
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_lit_res: assert property (op == 3'h1 |=> acc == k_ff - a_ff)
      else $error("literal sub result");
   a_lit_bor: assert property (op == 3'h1 |=> borrow_flag == (a_ff <= k_ff) &&
      nibble_borrow_flag == (a_ff[3:0] <= k_ff[3:0])) else $error("literal sub flags");
   a_file_res: assert property (op == 3'h2 && !dest_sel |=> acc == f_ff - a_ff)
      else $error("file sub result");
   a_file_bor: assert property (op == 3'h2 |=> borrow_flag == (a_ff <= f_ff))
      else $error("file sub borrow");
   a_dest_file: assert property (op inside {3'h2, 3'h3, 3'h5} && dest_sel |=>
      file_we && acc == a_ff) else $error("file destination");
   a_xor_file: assert property (op == 3'h3 && !dest_sel |=>
      acc == (a_ff ^ f_ff) && $stable(borrow_flag)) else $error("xor file");
   a_swap_res: assert property (op == 3'h5 && dest_sel |=>
      file_wdata == {f_ff[3:0], f_ff[7:4]} && $stable(zero_flag)) else $error("swap");
   a_xor_lit: assert property (op == 3'h4 |=>
      acc == (a_ff ^ k_ff) && $stable(nibble_borrow_flag)) else $error("xor literal");
   a_zero_val: assert property (op inside {3'h1, 3'h4} |=> zero_flag == (acc == 8'h00))
      else $error("zero flag");
   a_idle_hold: assert property (!(op inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) |=>
      $stable(acc) && !file_we && $stable(zero_flag) && $stable(borrow_flag))
      else $error("idle operation changed state");
   c_sub_file: cover property (op == 3'h2 && dest_sel);
   c_swap: cover property (op == 3'h5);
   c_xor_lit: cover property (op == 3'h4);
endmodule // sxa_alu_props
bind sxa_alu sxa_alu_props u_props (.clk(clk), .arst_n(arst_n), .dest_sel(dest_sel),
   .file_we(file_we), .borrow_flag(borrow_flag), .nibble_borrow_flag(nibble_borrow_flag),
   .zero_flag(zero_flag), .op(op), .literal(literal), .file_rdata(file_rdata), .acc(acc),
   .file_wdata(file_wdata));

// ---- verif/sxa_alu_tb.sv ----
// Bench driving the datapath against a register file model.
// Assumes the checker binds itself onto the datapath.
`timescale 1ns/100ps
module sxa_alu_tb import sxa_pkg::*; ;
   sxa_op_t op = SXA_OP_NONE;
   logic clk = 0, arst_n = 0, dest_sel = 0, file_we, borrow_flag, nibble_borrow_flag, zero_flag;
   logic [7:0] literal = 8'h00, file_rdata, acc, file_wdata;
   logic [6:0] file_addr = 7'h00, file_waddr;
   int err_count = 0, compares = 0;
   // Clock, design and its register file
   always #25 clk = ~clk;
   sxa_alu u_dut (.clk(clk), .arst_n(arst_n), .op(op), .literal(literal), .file_addr(file_addr),
      .file_rdata(file_rdata), .dest_sel(dest_sel), .acc(acc), .borrow_flag(borrow_flag),
      .nibble_borrow_flag(nibble_borrow_flag), .zero_flag(zero_flag), .file_we(file_we),
      .file_waddr(file_waddr), .file_wdata(file_wdata));
   sxa_rf_model u_rf (.clk(clk), .rd_addr(file_addr), .rd_data(file_rdata), .we(file_we),
      .waddr(file_waddr), .wdata(file_wdata));
   function automatic logic [7:0] flg();
      return {5'h00, borrow_flag, nibble_borrow_flag, zero_flag};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One operation, results looked at mid-cycle afterwards
   task automatic run(input logic [2:0] o, input logic [7:0] k, input logic [6:0] a,
      input logic d);
      @(posedge clk);
      op <= sxa_op_t'(o);
      literal <= k;
      file_addr <= a;
      dest_sel <= d;
      @(posedge clk);
      op <= SXA_OP_NONE;
      @(negedge clk);
   endtask
   task automatic t_sub();
      run(3'h1, 8'h05, 7'h00, 1'b0);
      chk(flg(), 8'h06);
      run(3'h1, 8'h03, 7'h00, 1'b0);
      chk(acc, 8'hfe);
      chk(flg(), 8'h00);
      u_rf.mem[7] = 8'h10;
      run(3'h2, 8'h00, 7'h07, 1'b1);
      chk(file_wdata, 8'h12);
      chk(acc, 8'hfe);
      run(3'h2, 8'h00, 7'h07, 1'b0);
      chk(acc, 8'h14);
      chk(flg(), 8'h00);
   endtask
   task automatic t_logic();
      u_rf.mem[127] = 8'h12;
      run(3'h4, 8'h14, 7'h00, 1'b0);
      chk(flg(), 8'h01);
      run(3'h3, 8'h00, 7'h7f, 1'b0);
      chk(acc, 8'h12);
      run(3'h2, 8'h00, 7'h07, 1'b0);
      chk(flg(), 8'h07);
      run(3'h5, 8'h00, 7'h07, 1'b1);
      chk(file_wdata, 8'h21);
      chk({1'b0, file_waddr}, 8'h07);
      chk({7'h00, file_we}, 8'h01);
      chk(flg(), 8'h07);
      run(3'h5, 8'h00, 7'h7f, 1'b0);
      chk(acc, 8'h21);
      chk({7'h00, file_we}, 8'h00);
      run(3'h3, 8'h00, 7'h7f, 1'b1);
      chk(file_wdata, 8'h33);
      chk({1'b0, file_waddr}, 8'h7f);
      chk(acc, 8'h21);
      chk(flg(), 8'h06);
      run(3'h6, 8'h00, 7'h07, 1'b0);
      chk(acc, 8'h21);
      chk(flg(), 8'h06);
      chk({7'h00, file_we}, 8'h00);
   endtask
   task automatic stop_test();
      $display("errors=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Reset, scenarios, verdict
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_sub();
      t_logic();
      stop_test();
   end
   // Watchdog far beyond the few dozen cycles needed
   initial begin
      #100000;
      err_count++;
      stop_test();
   end
endmodule // sxa_alu_tb
